// file: hw/dbctx_unit.sv
/*
  Data-block context unit: open, call/return context, range-checked
  bit, load and transfer access to data words.
  Assumes the instruction sequencer presents one op per op_valid pulse
  and supplies block start/length from the block directory.
*/
// Notes on behaviour
// - Open takes effect unless in stop mode, any block
// - Separate open ops for ordinary, extended
// - Data accesses address the open block
// - Open block stays current inside callee
// - Callee open is local; caller restored
// - Bit read forms logic result, no write
// - Set/reset writes logic result into bit
// - Load copies word into first accumulator
// - Transfer overwrites word from accumulator
// - Out-of-block load/transfer raises error
// - Load/transfer word numbers up to 255
// - Context ends on reopen or block end
// - Block one lists I/O and flags
// - With I/O list, update listed only
// - Words 16 bits, ascending from zero
// - Call saves open block start, length
// - Nesting over 62 errors and stops
`timescale 1ns/1ps
module dbctx_unit
  import dbctx_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  // Instruction port
  input  wire logic                    op_valid,
  input  wire logic [3:0]              op_code,
  input  wire logic [DBCTX_NUM_W-1:0]  op_block,
  input  wire logic [DBCTX_ADDR_W-1:0] op_word,
  input  wire logic [DBCTX_BIT_W-1:0]  op_bit,
  input  wire logic                    end_cond_true,
  // Block directory answer for op_block
  input  wire logic [DBCTX_ADDR_W-1:0] dir_start,
  input  wire logic [DBCTX_ADDR_W-1:0] dir_len,
  // Processor state
  input  wire logic                    logic_result_in,
  input  wire logic [DBCTX_WORD_W-1:0] accu_in,
  // Results
  output logic                         logic_result_bit,
  output logic [DBCTX_WORD_W-1:0]      first_accumulator,
  output logic                         accu_write,
  output logic                         lt_error,
  output logic                         nest_error,
  output logic                         stop_mode,
  output logic                         reserved_open,
  output logic                         block_open,
  output logic                         open_is_ext,
  output logic [DBCTX_NUM_W-1:0]       open_num
);
  // Memory of data words, addressed by absolute word address
  logic [DBCTX_WORD_W-1:0] dmem [DBCTX_MEM_WORDS];

  dbctx_state_e state;
  dbctx_state_e next_state;
  logic [DBCTX_ADDR_W-1:0] cur_start;
  logic [DBCTX_ADDR_W-1:0] cur_len;
  logic [DBCTX_ADDR_W-1:0] next_start;
  logic [DBCTX_ADDR_W-1:0] next_len;
  logic                    next_open;
  logic                    next_ext;
  logic [DBCTX_NUM_W-1:0]  next_num;
  logic                    next_lrb;
  logic [DBCTX_WORD_W-1:0] next_accu;
  logic                    next_accu_write;
  logic                    next_lt_error;
  logic                    next_nest_error;
  logic                    next_reserved;
  logic                    mem_we;
  logic [DBCTX_MEM_AW-1:0] mem_addr;
  logic [DBCTX_WORD_W-1:0] mem_wdata;
  logic [DBCTX_WORD_W-1:0] rd_word;
  logic [DBCTX_ADDR_W-1:0] abs_addr;
  logic                    in_range;
  logic                    is_end;
  logic                    push;
  logic                    pop;
  logic [DBCTX_ADDR_W-1:0] top_start;
  logic [DBCTX_ADDR_W-1:0] top_len;
  logic                    top_ext;
  logic [DBCTX_NUM_W-1:0]  top_num;
  logic                    top_opened;
  logic [DBCTX_DEPTH_W-1:0] depth;
  dbctx_op_e               op;

  assign op = dbctx_op_e'(op_code);

  dbctx_stack u_stack (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .push        (push),
    .pop         (pop),
    .push_start  (cur_start),
    .push_len    (cur_len),
    .push_ext    (open_is_ext),
    .push_num    (open_num),
    .push_opened (block_open),
    .top_start   (top_start),
    .top_len     (top_len),
    .top_ext     (top_ext),
    .top_num     (top_num),
    .top_opened  (top_opened),
    .depth       (depth)
  );

  // Address and range check against the open block
  always_comb begin
    abs_addr = cur_start + op_word;
    in_range = block_open && (op_word < cur_len)
               && (op_word <= {7'h00, DBCTX_MAX_WORD});
    mem_addr = abs_addr[DBCTX_MEM_AW-1:0];
    rd_word  = dmem[mem_addr];
    is_end   = (op == DBCTX_OP_END) || (op == DBCTX_OP_END_UNCON)
               || ((op == DBCTX_OP_END_COND) && end_cond_true);
  end

  // Next context, results and memory write
  always_comb begin
    next_state      = state;
    next_start      = cur_start;
    next_len        = cur_len;
    next_open       = block_open;
    next_ext        = open_is_ext;
    next_num        = open_num;
    next_lrb        = logic_result_bit;
    next_accu       = first_accumulator;
    next_accu_write = 1'b0;
    next_lt_error   = 1'b0;
    next_nest_error = nest_error;
    next_reserved   = 1'b0;
    mem_we          = 1'b0;
    mem_wdata       = rd_word;
    push            = 1'b0;
    pop             = 1'b0;
    if (op_valid && (state == DBCTX_ST_RUN)) begin
      unique case (op)
        DBCTX_OP_OPEN_DB, DBCTX_OP_OPEN_DX: begin
          // Unconditional open, replaces any earlier context
          next_open  = 1'b1;
          next_ext   = (op == DBCTX_OP_OPEN_DX);
          next_num   = op_block;
          next_start = dir_start;
          next_len   = dir_len;
          // Flag reserved numbers for the sequencer; the address list and
          // I/O list contents are kept by the system program, not here
          next_reserved = (op_block <= 8'h01)
                          || ((op == DBCTX_OP_OPEN_DX) && (op_block == 8'h02));
        end
        DBCTX_OP_CALL: begin
          if (depth == DBCTX_DEPTH_MAX) begin
            next_nest_error = 1'b1;
            next_state      = DBCTX_ST_STOP;
          end else begin
            push = 1'b1;
          end
        end
        DBCTX_OP_END, DBCTX_OP_END_COND, DBCTX_OP_END_UNCON: begin
          if (is_end && (depth != '0)) begin
            // Return restores the caller's context
            pop        = 1'b1;
            next_start = top_start;
            next_len   = top_len;
            next_ext   = top_ext;
            next_num   = top_num;
            next_open  = top_opened;
          end else if (is_end) begin
            next_open = 1'b0;
          end
        end
        DBCTX_OP_BIT_READ: begin
          if (in_range)
            next_lrb = rd_word[op_bit];
          else
            next_lt_error = 1'b1;
        end
        DBCTX_OP_BIT_WRITE: begin
          if (in_range) begin
            mem_we             = 1'b1;
            mem_wdata[op_bit]  = logic_result_in;
          end else begin
            next_lt_error = 1'b1;
          end
        end
        DBCTX_OP_LOAD: begin
          if (in_range) begin
            next_accu       = rd_word;
            next_accu_write = 1'b1;
          end else begin
            next_lt_error = 1'b1;
          end
        end
        DBCTX_OP_TRANSFER: begin
          if (in_range) begin
            mem_we    = 1'b1;
            mem_wdata = accu_in;
          end else begin
            next_lt_error = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Context and result registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state             <= DBCTX_ST_RUN;
      cur_start         <= '0;
      cur_len           <= '0;
      block_open        <= 1'b0;
      open_is_ext       <= 1'b0;
      open_num          <= DBCTX_RST_NUM;
      logic_result_bit  <= 1'b0;
      first_accumulator <= '0;
      accu_write        <= 1'b0;
      lt_error          <= 1'b0;
      nest_error        <= 1'b0;
      reserved_open     <= 1'b0;
    end else begin
      state             <= next_state;
      cur_start         <= next_start;
      cur_len           <= next_len;
      block_open        <= next_open;
      open_is_ext       <= next_ext;
      open_num          <= next_num;
      logic_result_bit  <= next_lrb;
      first_accumulator <= next_accu;
      accu_write        <= next_accu_write;
      lt_error          <= next_lt_error;
      nest_error        <= next_nest_error;
      reserved_open     <= next_reserved;
    end
  end

  // Data word storage, only written by in-range accesses
  always_ff @(posedge ref_clk) begin
    if (mem_we)
      dmem[mem_addr] <= mem_wdata;
  end

  assign stop_mode = (state == DBCTX_ST_STOP);
endmodule

// file: hw/dbctx_pkg.sv
/*
  Constants and types shared by the data-block context unit.
  Assumes one clock domain; all counts are in instructions, not time.
*/
package dbctx_pkg;
  localparam int unsigned DBCTX_WORD_W   = 16;
  localparam int unsigned DBCTX_ADDR_W   = 15;
  localparam int unsigned DBCTX_NUM_W    = 8;
  localparam int unsigned DBCTX_BIT_W    = 4;
  localparam int unsigned DBCTX_DEPTH    = 62;
  localparam int unsigned DBCTX_DEPTH_W  = 6;
  localparam int unsigned DBCTX_MEM_WORDS = 1024;
  localparam int unsigned DBCTX_MEM_AW   = 10;
  localparam logic [7:0]  DBCTX_MAX_WORD = 8'hff;
  localparam logic [5:0]  DBCTX_DEPTH_MAX = 6'h3e;
  localparam logic [DBCTX_NUM_W-1:0] DBCTX_RST_NUM = 8'h00;

  // Operation codes presented with op_valid
  typedef enum logic [3:0] {
    DBCTX_OP_NOP       = 4'h0,
    DBCTX_OP_OPEN_DB   = 4'h1,
    DBCTX_OP_OPEN_DX   = 4'h2,
    DBCTX_OP_CALL      = 4'h3,
    DBCTX_OP_END       = 4'h4,
    DBCTX_OP_END_COND  = 4'h5,
    DBCTX_OP_END_UNCON = 4'h6,
    DBCTX_OP_BIT_READ  = 4'h7,
    DBCTX_OP_BIT_WRITE = 4'h8,
    DBCTX_OP_LOAD      = 4'h9,
    DBCTX_OP_TRANSFER  = 4'ha
  } dbctx_op_e;

  typedef enum logic [1:0] {
    DBCTX_ST_RUN  = 2'b01,
    DBCTX_ST_STOP = 2'b10
  } dbctx_state_e;
endpackage

// file: hw/dbctx_stack.sv
/*
  Context stack of the data-block unit: one entry per nested call.
  Assumes the caller never pushes when full and never pops when empty.
*/
`timescale 1ns/1ps
module dbctx_stack
  import dbctx_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  // Stack control
  input  wire logic                    push,
  input  wire logic                    pop,
  input  wire logic [DBCTX_ADDR_W-1:0] push_start,
  input  wire logic [DBCTX_ADDR_W-1:0] push_len,
  input  wire logic                    push_ext,
  input  wire logic [DBCTX_NUM_W-1:0]  push_num,
  input  wire logic                    push_opened,
  // Stack state
  output logic [DBCTX_ADDR_W-1:0]      top_start,
  output logic [DBCTX_ADDR_W-1:0]      top_len,
  output logic                         top_ext,
  output logic [DBCTX_NUM_W-1:0]       top_num,
  output logic                         top_opened,
  output logic [DBCTX_DEPTH_W-1:0]     depth
);
  localparam int unsigned ENT_W = 2*DBCTX_ADDR_W + DBCTX_NUM_W + 2;

  logic [ENT_W-1:0]         mem [DBCTX_DEPTH];
  logic [DBCTX_DEPTH_W-1:0] next_depth;
  logic [DBCTX_DEPTH_W-1:0] top_idx;

  // Depth counter
  always_comb begin
    next_depth = depth;
    if (push)
      next_depth = depth + 6'h01;
    else if (pop)
      next_depth = depth - 6'h01;
  end

  always_ff @(posedge ref_clk) begin
    if (srst)
      depth <= '0;
    else
      depth <= next_depth;
  end

  // Entry storage, written on push
  always_ff @(posedge ref_clk) begin
    if (push)
      mem[depth] <= {push_start, push_len, push_ext, push_num, push_opened};
  end

  // Top of stack view
  always_comb begin
    top_idx = (depth == '0) ? '0 : depth - 6'h01;
    {top_start, top_len, top_ext, top_num, top_opened} = mem[top_idx];
  end
endmodule

// file: bench/dbctx_unit_monitor.sv
/*
  Port checker for dbctx_unit, bound to every instance.
  Assumes one clock ref_clk and synchronous active-high srst.
*/
`timescale 1ns/1ps
module dbctx_unit_monitor
  import dbctx_pkg::*;
(
  // Clock, reset, instruction
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        op_valid,
  input wire logic [3:0]  op_code,
  input wire logic [7:0]  op_block,
  input wire logic [14:0] op_word,
  // Results and context
  input wire logic        accu_write,
  input wire logic        lt_error,
  input wire logic        nest_error,
  input wire logic        stop_mode,
  input wire logic        reserved_open,
  input wire logic        block_open,
  input wire logic        open_is_ext,
  input wire logic [7:0]  open_num
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // Op accepted this cycle
  logic tk;
  assign tk = op_valid & ~stop_mode;
  // Opens, reserved numbers, range, load, overflow, context hold
  property p_open_db;
    tk && op_code == DBCTX_OP_OPEN_DB |=>
      block_open && !open_is_ext && open_num == $past(op_block);
  endproperty
  a_open_db: assert property (p_open_db) else $error("db open");
  property p_open_dx;
    tk && op_code == DBCTX_OP_OPEN_DX |=>
      block_open && open_is_ext && open_num == $past(op_block);
  endproperty
  a_open_dx: assert property (p_open_dx) else $error("dx open");
  property p_resv;
    tk && (op_code == DBCTX_OP_OPEN_DB && op_block < 8'h02 ||
      op_code == DBCTX_OP_OPEN_DX && op_block < 8'h03) |=> reserved_open;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved");
  property p_word_max;
    tk && op_code inside {DBCTX_OP_LOAD, DBCTX_OP_TRANSFER} &&
      op_word > 15'h00ff |=> lt_error && !accu_write;
  endproperty
  a_word_max: assert property (p_word_max) else $error("word max");
  property p_accw;
    accu_write |-> $past(op_valid) && !$past(stop_mode) &&
      $past(op_code) == DBCTX_OP_LOAD;
  endproperty
  a_accw: assert property (p_accw) else $error("accu write");
  property p_nest;
    nest_error |=> nest_error && stop_mode;
  endproperty
  a_nest: assert property (p_nest) else $error("nest lost");
  property p_stop;
    stop_mode |=> !accu_write && !lt_error && !reserved_open;
  endproperty
  a_stop: assert property (p_stop) else $error("stop busy");
  property p_hold;
    !op_valid |=> $stable(open_num) && $stable(block_open);
  endproperty
  a_hold: assert property (p_hold) else $error("ctx moved");
endmodule

bind dbctx_unit dbctx_unit_monitor u_mon (.*);

// file: bench/tb_dbctx_unit.sv
/*
  Random self-checking bench for dbctx_unit with a reference model.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
module tb_dbctx_unit
  import dbctx_pkg::*;
;
  typedef struct packed {
    logic o, x;
    logic [7:0] n;
    logic [14:0] s, l;
  } dbctx_ctx_s;
  // Design ports, inputs quiet at time zero
  logic        ref_clk = 1'b0, srst = 1'b1, op_valid = 1'b0;
  logic        end_cond_true = 1'b0, logic_result_in = 1'b0;
  logic [3:0]  op_code = 4'h0, op_bit = 4'h0;
  logic [7:0]  op_block = 8'h00, open_num;
  logic [14:0] op_word = 15'h0000, dir_start = 15'h0000;
  logic [14:0] dir_len = 15'h0000;
  logic [15:0] accu_in = 16'h0000, first_accumulator;
  logic        logic_result_bit, accu_write, lt_error, nest_error;
  logic        stop_mode, reserved_open, block_open, open_is_ext;
  // Reference model
  dbctx_ctx_s  m = '0;
  dbctx_ctx_s  stk[$];
  logic [15:0] mem [1024];
  logic [15:0] m_acc = 16'h0000;
  logic [14:0] rw;
  logic        m_stop = 1'b0;
  int          n_mismatch = 0, checks = 0;

  dbctx_unit dut (.*);

  // Clock, 40 ns period
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // Verdict and end of run
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One instruction; standing context is compared first
  task automatic op(input dbctx_op_e c, input logic [7:0] b = 8'h00,
      input logic [14:0] w = '0, s = '0, l = '0, input logic t = 1'b1);
    chk("open", 16'(block_open), 16'(m.o));
    if (m.o) chk("ctx", 16'({open_is_ext, open_num}), 16'({m.x, m.n}));
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_block <= b;
    op_word <= w;
    dir_start <= s;
    dir_len <= l;
    end_cond_true <= t;
    accu_in <= 16'($urandom);
    op_bit <= 4'($urandom);
    logic_result_in <= 1'($urandom);
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
  endtask

  // Data access with range check and model update
  task automatic acc(input dbctx_op_e c, input logic [14:0] w);
    logic ok;
    logic [9:0] a;
    ok = m.o && w < m.l && w <= 15'h00ff && !m_stop;
    a = 10'(m.s + w);
    op(c, 8'h00, w);
    chk("lt", 16'(lt_error), 16'(!m_stop && !ok));
    if (ok) begin
      case (c)
        DBCTX_OP_LOAD: m_acc = mem[a];
        DBCTX_OP_TRANSFER: mem[a] = accu_in;
        DBCTX_OP_BIT_WRITE: mem[a][op_bit] = logic_result_in;
        default: chk("rlo", 16'(logic_result_bit), 16'(mem[a][op_bit]));
      endcase
    end
    chk("acc", first_accumulator, m_acc);
    chk("aw", 16'(accu_write), 16'(ok && c == DBCTX_OP_LOAD));
  endtask

  task automatic open_blk(input logic x, input logic [7:0] n,
      input logic [14:0] s, l);
    op(x ? DBCTX_OP_OPEN_DX : DBCTX_OP_OPEN_DB, n, '0, s, l);
    if (!m_stop) m = '{1'b1, x, n, s, l};
    chk("rsv", 16'(reserved_open), 16'(!m_stop && n < 8'(2 + x)));
  endtask

  task automatic call_blk();
    op(DBCTX_OP_CALL);
    if (stk.size() == 62) m_stop = 1'b1;
    else if (!m_stop) stk.push_back(m);
    chk("nest", 16'({nest_error, stop_mode}), 16'({2{m_stop}}));
  endtask

  task automatic end_blk(input dbctx_op_e c, input logic t = 1'b1);
    op(c, 8'h00, '0, '0, '0, t);
    if (!m_stop && (t || c != DBCTX_OP_END_COND)) begin
      if (stk.size() > 0) m = stk.pop_back();
      else m = '0;
    end
  endtask

  // Watchdog
  initial begin
    #200us;
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    void'($urandom(14));
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    // Every reserved number once; single processor, so no I/O list load
    for (int i = 0; i < 8; i++)
      open_blk(i[0], 8'(i / 2), '0, '0);
    open_blk(1'b0, 8'h14, 15'h0069, 15'h0004);
    for (int i = 0; i < 4; i++) acc(DBCTX_OP_TRANSFER, 15'(i));
    repeat (2) open_blk(1'b0, 8'h0a, 15'h0064, 15'h0005);
    for (int i = 0; i < 6; i++) acc(DBCTX_OP_TRANSFER, 15'(i));
    for (int i = 0; i < 6; i++) acc(DBCTX_OP_LOAD, 15'(i));
    repeat (8) begin
      rw = 15'($urandom_range(4));
      acc(DBCTX_OP_BIT_WRITE, rw);
      acc(DBCTX_OP_BIT_READ, rw);
      acc(DBCTX_OP_LOAD, rw);
    end
    call_blk();
    acc(DBCTX_OP_LOAD, 15'h0001);
    open_blk(1'b0, 8'h14, 15'h0069, 15'h0004);
    acc(DBCTX_OP_LOAD, 15'h0000);
    end_blk(DBCTX_OP_END_COND, 1'b0);
    end_blk(DBCTX_OP_END_COND, 1'b1);
    acc(DBCTX_OP_LOAD, 15'h0002);
    call_blk();
    open_blk(1'b1, 8'h1e, 15'h012c, 15'h012c);
    for (int i = 0; i < 4; i++)
      acc(i[0] ? DBCTX_OP_LOAD : DBCTX_OP_TRANSFER, 15'(9'h0ff + i[1]));
    end_blk(DBCTX_OP_END_UNCON);
    call_blk();
    end_blk(DBCTX_OP_END);
    end_blk(DBCTX_OP_END);
    acc(DBCTX_OP_LOAD, 15'h0000);
    repeat (64) call_blk();
    open_blk(1'b0, 8'h00, '0, '0);
    acc(DBCTX_OP_LOAD, 15'h0000);
    // Mid-run reset leaves stop mode; data words are not cleared
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    m = '0;
    stk.delete();
    m_stop = 1'b0;
    m_acc = 16'h0000;
    chk("rst", 16'({nest_error, stop_mode, block_open}), 16'h0000);
    open_blk(1'b0, 8'h0a, 15'h0064, 15'h0005);
    acc(DBCTX_OP_LOAD, 15'h0001);
    call_blk();
    report_and_stop();
  end
endmodule
